// file: pkg/serial_port_defines.vh
// Purpose: constants for the asynchronous terminal-side serial port
// Assumes: 25 MHz reference clock
// Notes:   bit timing derives from a 16x oversample tick
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// reference clock in Hz
`define CLK_HZ            25000000
// default baud rate
`define BAUD_DEFAULT      9600
// receiver oversampling factor
`define OVERSAMPLE        16
// ticks of the oversample clock per bit
`define TICKS_PER_BIT     5'd16
// half-bit point measured in ticks, centre of a bit
`define TICKS_HALF_BIT    5'd8
// 1.42 stop in sixteenths: 23 ticks is the least whole count at or above 22.72
`define TICKS_STOP_142    6'd23
`define TICKS_STOP_1      6'd16
`define TICKS_STOP_2      6'd32
// stop length selector codes
`define STOP_SEL_1        2'h0
`define STOP_SEL_142      2'h1
`define STOP_SEL_2        2'h2
// character length select: 0 = 5 bits .. 3 = 8 bits
`define LEN_BASE          4'd5
// fifo shape
`define FIFO_WIDTH        8
`define FIFO_DEPTH        8
`define FIFO_AW           3
// idle level on data and off level on control lines
`define LINE_MARK         1'b1
`define CTRL_OFF          1'b1
`define CTRL_ON           1'b0

`endif

// file: logic/char_fifo.v
// Purpose: small character fifo between the user and the transmitter
// Assumes: one clock, same domain on both sides
// Notes:   full and empty come from a separate count
`timescale 1ns/100ps
`default_nettype none
module char_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             ref_clk,
   input  wire             rst_n,
   // fill side
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   // drain side
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   reg             rdy_q;
   wire [AW:0]     cnt_d;
   wire            push;
   wire            pop;

   assign in_ready  = rdy_q; // registered, so ready leaves the top from a flop
   assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage has no reset, only pointers, count and ready do
   always @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and occupancy
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         rdy_q <= 1'b1;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         rdy_q <= (cnt_d != DEPTH[AW:0]);
      end
   end
endmodule // char_fifo
`default_nettype wire

// file: logic/pin_sync.v
// Purpose: three-stage synchroniser for one pin
// Assumes: pin is asynchronous to ref_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter RESET_VAL = 1'b1
) (
   // clock and reset
   input  wire ref_clk,
   input  wire rst_n,
   // pin and clean level
   input  wire pin_in,
   output reg  level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // first stage feeds only the second
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q    <= RESET_VAL;
         s2_q    <= RESET_VAL;
         s3_q    <= RESET_VAL;
         level_q <= RESET_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule // pin_sync
`default_nettype wire

// file: logic/async_serial_dte_port.v
// Purpose: terminal-side asynchronous serial port with modem control lines
// Assumes: 25 MHz ref_clk; modem lines and rx data arrive asynchronously
// Notes:   no parity; tx fed from an 8-entry fifo; control pins active low
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_defines.vh"

// Summary of operation
// - each sent character opens with one start bit at zero
// - stop at one follows data; line stays one until next start
// - receiver accepts any idle length between characters
// - least stop length selectable as one, 1.42 or two bits
// - character holds five to eight data bits, both directions
// - start falling edge resets receiver timing; bits sampled mid-interval
// - characters are sent as soon as available, gaps may vary
// - no clock on the link; bit timing from local clock
// - each bit lasts one over the baud rate; code makes it 16 ticks of a divider rounded down, 208 clocks at 115200
// - on data lines mark is one, space is zero
// - on control lines on is zero, off is one
// - port offers tx, rx, rts, cts, dsr, carrier detect, dtr
// - transmit line held marking when idle and between characters
// - no new character starts while clear-to-send is off
// - data terminal ready held on keeps equipment connected
// - request-to-send puts equipment in transmit mode
module async_serial_dte_port #(
   parameter BAUD = `BAUD_DEFAULT
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       rst_n,
   // framing setup
   input  wire [1:0] len_sel,
   input  wire [1:0] stop_sel,
   // transmit characters in
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   output wire       tx_ready,
   // receive characters out
   output reg  [7:0] rx_data_q,
   output reg        rx_valid_q,
   output reg        rx_frame_err_q,
   // modem control from user, active high
   input  wire       dtr_req,
   input  wire       rts_req,
   // modem and transmit status to user, active high
   output reg        cts_on_q,
   output reg        dsr_on_q,
   output reg        cd_on_q,
   output reg        tx_busy_q,
   // serial pins
   output reg        txd_q,
   input  wire       rxd,
   output reg        rts_n_q,
   output reg        dtr_n_q,
   input  wire       cts_n,
   input  wire       dsr_n,
   input  wire       cd_n
);
   // tick divider: 16x baud, rounded down
   localparam [31:0] TICK_DIV = `CLK_HZ / (BAUD * `OVERSAMPLE);
   localparam [15:0] TICK_MAX = TICK_DIV[15:0] - 16'h0001;
   localparam [1:0] TX_IDLE  = 2'd0;
   localparam [1:0] TX_START = 2'd1;
   localparam [1:0] TX_DATA  = 2'd2;
   localparam [1:0] TX_STOP  = 2'd3;
   localparam [1:0] RX_IDLE  = 2'd0;
   localparam [1:0] RX_START = 2'd1;
   localparam [1:0] RX_DATA  = 2'd2;
   localparam [1:0] RX_STOP  = 2'd3;
   reg  [15:0] div_q;
   reg         tick_q;
   wire        rxd_s;
   wire        cts_s;
   wire        dsr_s;
   wire        cd_s;
   wire [7:0]  f_data;
   wire        f_valid;
   reg         f_pop;
   reg  [1:0]  tx_st_q;
   reg  [5:0]  tx_tk_q;
   reg  [2:0]  tx_bit_q;
   reg  [7:0]  tx_sh_q;
   reg  [2:0]  tx_last_q;
   reg  [5:0]  tx_stop_q;
   reg  [1:0]  rx_st_q;
   reg  [4:0]  rx_tk_q;
   reg  [2:0]  rx_bit_q;
   reg  [7:0]  rx_sh_q;
   reg  [2:0]  rx_last_q;
   reg         rxd_prev_q;
   // last data-bit index for a length code
   function [2:0] last_bit;
      input [1:0] sel;
      begin
         last_bit = 3'd4 + {1'b0, sel};
      end
   endfunction

   // stop length in ticks for a selector code
   function [5:0] stop_ticks;
      input [1:0] sel;
      begin
         case (sel)
            `STOP_SEL_142: stop_ticks = `TICKS_STOP_142;
            `STOP_SEL_2:   stop_ticks = `TICKS_STOP_2;
            default:       stop_ticks = `TICKS_STOP_1;
         endcase
      end
   endfunction

   // clean levels of the pins from the far side
   pin_sync #(.RESET_VAL(`LINE_MARK)) u_rxd (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (rxd),
      .level_q (rxd_s)
   );
   pin_sync #(.RESET_VAL(`CTRL_OFF)) u_cts (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (cts_n),
      .level_q (cts_s)
   );
   pin_sync #(.RESET_VAL(`CTRL_OFF)) u_dsr (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (dsr_n),
      .level_q (dsr_s)
   );
   pin_sync #(.RESET_VAL(`CTRL_OFF)) u_cd (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (cd_n),
      .level_q (cd_s)
   );

   // pending characters wait here; tx_ready drops when full
   char_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   // 16x baud tick from the local clock, shared by both directions
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         if (div_q == TICK_MAX) begin
            div_q  <= 16'h0000;
            tick_q <= 1'b1;
         end else begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
         end
      end
   end

   // take a character on a tick when idle and cts is on; start bit is whole ticks
   always @* begin
      f_pop = (tx_st_q == TX_IDLE) && f_valid && (cts_s == `CTRL_ON) && tick_q;
   end

   // transmitter: start, data lsb first, stop
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_q   <= TX_IDLE;
         tx_tk_q   <= 6'h00;
         tx_bit_q  <= 3'h0;
         tx_sh_q   <= 8'h00;
         tx_last_q <= 3'h7;
         tx_stop_q <= `TICKS_STOP_1;
         txd_q     <= `LINE_MARK;
         tx_busy_q <= 1'b0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               txd_q     <= `LINE_MARK;
               tx_busy_q <= tx_busy_q & ~tick_q; // held to the tick closing the stop
               if (f_pop) begin
                  tx_sh_q   <= f_data;
                  tx_last_q <= last_bit(len_sel);
                  tx_stop_q <= stop_ticks(stop_sel);
                  tx_tk_q   <= 6'h00;
                  tx_st_q   <= TX_START;
                  txd_q     <= 1'b0;
                  tx_busy_q <= 1'b1;
               end
            end
            TX_START: begin
               if (tick_q) begin
                  if (tx_tk_q == {1'b0, `TICKS_PER_BIT} - 6'h01) begin
                     tx_tk_q  <= 6'h00;
                     tx_bit_q <= 3'h0;
                     txd_q    <= tx_sh_q[0];
                     tx_st_q  <= TX_DATA;
                  end else begin
                     tx_tk_q <= tx_tk_q + 6'h01;
                  end
               end
            end
            TX_DATA: begin
               if (tick_q) begin
                  if (tx_tk_q == {1'b0, `TICKS_PER_BIT} - 6'h01) begin
                     tx_tk_q <= 6'h00;
                     if (tx_bit_q == tx_last_q) begin
                        txd_q   <= `LINE_MARK;
                        tx_st_q <= TX_STOP;
                     end else begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        txd_q    <= tx_sh_q[1];
                     end
                  end else begin
                     tx_tk_q <= tx_tk_q + 6'h01;
                  end
               end
            end
            TX_STOP: begin
               // last stop tick is spent in idle, which pops only on a tick
               if (tick_q) begin
                  if (tx_tk_q == tx_stop_q - 6'h02) begin
                     tx_tk_q <= 6'h00;
                     tx_st_q <= TX_IDLE;
                  end else begin
                     tx_tk_q <= tx_tk_q + 6'h01;
                  end
               end
            end
            default: begin
               tx_st_q <= TX_IDLE;
               txd_q   <= `LINE_MARK;
            end
         endcase
      end
   end

   // receiver: falling edge restarts timing, sample at bit centres
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_q        <= RX_IDLE;
         rx_tk_q        <= 5'h00;
         rx_bit_q       <= 3'h0;
         rx_sh_q        <= 8'h00;
         rx_last_q      <= 3'h7;
         rxd_prev_q     <= `LINE_MARK;
         rx_data_q      <= 8'h00;
         rx_valid_q     <= 1'b0;
         rx_frame_err_q <= 1'b0;
      end else begin
         rxd_prev_q <= rxd_s;
         rx_valid_q <= 1'b0;
         case (rx_st_q)
            RX_IDLE: begin
               // stays here for any idle length
               if (rxd_prev_q && !rxd_s) begin
                  rx_tk_q   <= 5'h00;
                  rx_last_q <= last_bit(len_sel);
                  rx_st_q   <= RX_START;
               end
            end
            RX_START: begin
               if (tick_q) begin
                  if (rx_tk_q == `TICKS_HALF_BIT - 5'h01) begin
                     rx_tk_q <= 5'h00;
                     // glitch shorter than half a bit: back to idle
                     rx_st_q <= rxd_s ? RX_IDLE : RX_DATA;
                     rx_bit_q <= 3'h0;
                  end else begin
                     rx_tk_q <= rx_tk_q + 5'h01;
                  end
               end
            end
            RX_DATA: begin
               if (tick_q) begin
                  if (rx_tk_q == `TICKS_PER_BIT - 5'h01) begin
                     rx_tk_q <= 5'h00;
                     rx_sh_q[rx_bit_q] <= rxd_s;
                     if (rx_bit_q == rx_last_q) begin
                        rx_st_q <= RX_STOP;
                     end else begin
                        rx_bit_q <= rx_bit_q + 3'h1;
                     end
                  end else begin
                     rx_tk_q <= rx_tk_q + 5'h01;
                  end
               end
            end
            RX_STOP: begin
               if (tick_q) begin
                  if (rx_tk_q == `TICKS_PER_BIT - 5'h01) begin
                     rx_tk_q        <= 5'h00;
                     rx_data_q      <= rx_sh_q;
                     rx_valid_q     <= 1'b1;
                     rx_frame_err_q <= ~rxd_s;
                     rx_sh_q        <= 8'h00;
                     rx_st_q        <= RX_IDLE;
                  end else begin
                     rx_tk_q <= rx_tk_q + 5'h01;
                  end
               end
            end
            default: begin
               rx_st_q <= RX_IDLE;
            end
         endcase
      end
   end

   // modem lines: pins active low, user side active high
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rts_n_q  <= `CTRL_OFF;
         dtr_n_q  <= `CTRL_OFF;
         cts_on_q <= 1'b0;
         dsr_on_q <= 1'b0;
         cd_on_q  <= 1'b0;
      end else begin
         rts_n_q  <= ~rts_req;
         dtr_n_q  <= ~dtr_req;
         cts_on_q <= ~cts_s;
         dsr_on_q <= ~dsr_s;
         cd_on_q  <= ~cd_s;
      end
   end
endmodule // async_serial_dte_port
`default_nettype wire

// file: testbench/async_serial_dte_port_assertions.sv
// Purpose: pin and status checks for the terminal-side serial port
// Assumes: single clock, asynchronous active-low reset
// Notes:   bit length derived from BAUD the same way as the tick divider
`timescale 1ns/100ps
`default_nettype none
module serial_port_checks #(
   parameter BAUD = 9600
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // user side
   input wire logic dtr_req,
   input wire logic rts_req,
   input wire logic rx_valid_q,
   input wire logic rx_frame_err_q,
   input wire logic tx_ready,
   input wire logic tx_busy_q,
   input wire logic cts_on_q,
   input wire logic dsr_on_q,
   input wire logic cd_on_q,
   // pins
   input wire logic txd_q,
   input wire logic rts_n_q,
   input wire logic dtr_n_q,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic cd_n
);
   localparam int BIT = 16 * (25000000 / (BAUD * 16));
   logic [15:0] low_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // low run on tx line; any run must be whole bits
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         low_q <= 16'h0000;
      else if (!txd_q)
         low_q <= low_q + 16'h0001;
      else
         low_q <= 16'h0000;
   end
   dtr_follow_a:
      assert property (##1 dtr_n_q == !$past(dtr_req)) else $error("dtr pin not following request");
   rts_follow_a:
      assert property (rts_req |=> !rts_n_q) else $error("rts pin not on after request");
   cts_seen_a:
      assert property (!cts_n [*7] |-> cts_on_q) else $error("cts low but status off");
   dsr_seen_a:
      assert property (dsr_n [*7] |-> !dsr_on_q) else $error("dsr high but status on");
   cd_seen_a:
      assert property (!cd_n [*7] |-> cd_on_q) else $error("carrier low but status off");
   idle_mark_a:
      assert property (!tx_busy_q |-> txd_q) else $error("tx line not marking while idle");
   start_zero_a:
      assert property ($rose(tx_busy_q) |-> !txd_q) else $error("char did not open with zero");
   bit_len_a:
      assert property (tx_busy_q && $rose(txd_q) |-> low_q != 0 && low_q % BIT == 0) else $error("low run not whole bits");
   cts_hold_a:
      assert property (cts_n [*8] ##1 cts_n |-> !$rose(tx_busy_q)) else $error("char started with cts off");
   rx_pulse_a:
      assert property (rx_valid_q |=> !rx_valid_q) else $error("rx valid longer than a cycle");
   tx_start_c: cover property ($rose(tx_busy_q));
   rx_err_c: cover property (rx_valid_q && rx_frame_err_q);
   fifo_full_c: cover property (!tx_ready);
endmodule // serial_port_checks
bind async_serial_dte_port serial_port_checks #(.BAUD(BAUD)) chk_u (
   .ref_clk(ref_clk), .rst_n(rst_n), .dtr_req(dtr_req), .rts_req(rts_req), .rx_valid_q(rx_valid_q),
   .rx_frame_err_q(rx_frame_err_q), .tx_ready(tx_ready), .tx_busy_q(tx_busy_q), .cts_on_q(cts_on_q),
   .dsr_on_q(dsr_on_q), .cd_on_q(cd_on_q), .txd_q(txd_q), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q),
   .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n));
`default_nettype wire

// file: testbench/serial_dce_model.sv
// Purpose: communications equipment on the far side of the port
// Assumes: same bit length as the port, set by BIT
// Notes:   decodes tx frames into a queue, sends rx frames on request
`timescale 1ns/100ps
`default_nettype none
module serial_dce_model #(
   parameter int BIT = 208
) (
   // clock and settings
   input  wire logic       ref_clk,
   input  wire logic [3:0] nbits,
   input  wire logic       cts_on,
   input  wire logic       dsr_on,
   input  wire logic       cd_on,
   // pins
   input  wire logic       txd,
   output var  logic       rxd,
   output wire logic       cts_n,
   output wire logic       dsr_n,
   output wire logic       cd_n
);
   logic [9:0] got[$];
   int         gap[$];
   int         cyc = 0;
   int         st = 0;
   int         last = 0;
   logic [7:0] v;
   logic       s0;
   // control pins are on when low
   assign cts_n = !cts_on;
   assign dsr_n = !dsr_on;
   assign cd_n  = !cd_on;
   initial rxd = 1'b1;
   // free cycle count for start-to-start spacing
   always @(posedge ref_clk) cyc <= cyc + 1;
   // sample each frame at bit centres: start, stop and data
   always begin
      @(negedge txd);
      st = cyc;
      repeat (BIT / 2) @(posedge ref_clk);
      s0 = txd;
      v = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT) @(posedge ref_clk);
         v[i] = txd;
      end
      repeat (BIT) @(posedge ref_clk);
      got.push_back({s0, txd, v});
      gap.push_back(st - last);
      last = st;
   end
   // one frame on the receive line, lsb first
   task automatic send(input logic [7:0] d, input logic stop);
      rxd <= 1'b0;
      repeat (BIT) @(posedge ref_clk);
      for (int i = 0; i < nbits; i++) begin
         rxd <= d[i];
         repeat (BIT) @(posedge ref_clk);
      end
      rxd <= stop;
      repeat (BIT) @(posedge ref_clk);
      rxd <= 1'b1;
   endtask
endmodule // serial_dce_model
`default_nettype wire

// file: testbench/tb_async_serial_dte_port.sv
// Purpose: self-checking bench for the terminal-side serial port
// Assumes: 115200 baud so one bit is 208 clocks
// Notes:   far side is the equipment model; cts gates the fifo drain
`timescale 1ns/100ps
`default_nettype none
module tb_async_serial_dte_port;
   localparam int BAUD = 115200;
   localparam int TICK = 25000000 / (BAUD * 16);
   localparam int BIT  = 16 * TICK;
   logic       ref_clk, rst_n, tx_valid, tx_ready, rx_valid_q, rx_frame_err_q;
   logic       dtr_req, rts_req, cts_on_q, dsr_on_q, cd_on_q, tx_busy_q;
   logic       txd_q, rxd, rts_n_q, dtr_n_q, cts_n, dsr_n, cd_n, cts_on, dsr_on, cd_on;
   logic [1:0] len_sel, stop_sel;
   logic [7:0] tx_data, rx_data_q, d, m;
   logic [3:0] nb;
   int         error_cnt = 0, checks_done = 0, cycles = 0, c, k;
   async_serial_dte_port #(.BAUD(BAUD)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .len_sel(len_sel), .stop_sel(stop_sel), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q),
      .rx_frame_err_q(rx_frame_err_q), .dtr_req(dtr_req), .rts_req(rts_req), .cts_on_q(cts_on_q),
      .dsr_on_q(dsr_on_q), .cd_on_q(cd_on_q), .tx_busy_q(tx_busy_q), .txd_q(txd_q), .rxd(rxd),
      .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q), .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n));
   serial_dce_model #(.BIT(BIT)) model_u (
      .ref_clk(ref_clk), .nbits(nb), .cts_on(cts_on), .dsr_on(dsr_on), .cd_on(cd_on),
      .txd(txd_q), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // valid stays up between calls; caller drops it
   task automatic push(input logic [7:0] v);
      tx_data <= v;
      tx_valid <= 1'b1;
      @(posedge ref_clk);
      while (tx_ready !== 1'b1)
         @(posedge ref_clk);
   endtask
   task automatic wait_got(input int n);
      k = 0;
      while (model_u.got.size() < n && k < 40000) begin
         @(posedge ref_clk);
         k++;
      end
      chk("frames seen", n, model_u.got.size());
   endtask
   task automatic t_modem;
      for (int i = 0; i < 4; i++) begin
         dtr_req <= i[0];
         rts_req <= i[1];
         dsr_on <= i[0];
         cd_on <= i[1];
         cts_on <= i[0] | i[1];
         repeat (8) @(posedge ref_clk);
         chk("dtr pin", !i[0], dtr_n_q);
         chk("rts pin", !i[1], rts_n_q);
         chk("dsr status", i[0], dsr_on_q);
         chk("cd status", i[1], cd_on_q);
         chk("cts status", i[0] | i[1], cts_on_q);
      end
      $display("modem lines done");
   endtask
   task automatic t_tx_len;
      for (int l = 0; l < 4; l++) begin
         len_sel <= l[1:0];
         nb <= 4'(5 + l);
         @(posedge ref_clk);
         c = model_u.got.size();
         d = 8'hA5 ^ l[7:0];
         m = 8'hFF >> (3 - l);
         push(d);
         tx_valid <= 1'b0;
         wait_got(c + 1);
         chk("tx frame", {2'b01, d & m}, model_u.got[c]);
      end
      $display("tx lengths done");
   endtask
   task automatic t_stop;
      for (int s = 0; s < 4; s++) begin
         stop_sel <= s[1:0];
         @(posedge ref_clk);
         c = model_u.got.size();
         push(8'h5A);
         push(8'h0F);
         tx_valid <= 1'b0;
         wait_got(c + 2);
         k = model_u.gap[c + 1] - 9 * BIT - (s == 1 ? 23 : s == 2 ? 32 : 16) * TICK;
         chk("stop spacing", 1, k >= 0 && k <= 4);
         chk("second frame", 10'h10F, model_u.got[c + 1]);
      end
      stop_sel <= 2'd0;
      $display("stop lengths done");
   endtask
   task automatic t_fifo;
      cts_on <= 1'b0;
      repeat (400) @(posedge ref_clk);
      c = model_u.got.size();
      for (int i = 0; i < 8; i++)
         push(8'h30 + i[7:0]);
      tx_valid <= 1'b0;
      @(posedge ref_clk);
      chk("ready when full", 0, tx_ready);
      repeat (300) @(posedge ref_clk);
      chk("frames with cts off", c, model_u.got.size());
      chk("busy with cts off", 0, tx_busy_q);
      cts_on <= 1'b1;
      wait_got(c + 8);
      for (int i = 0; i < 8; i++)
         chk("drained frame", {2'b01, 8'h30 + i[7:0]}, model_u.got[c + i]);
      $display("fifo and cts done");
   endtask
   task automatic t_rx;
      for (int l = 0; l < 5; l++) begin
         d = 8'hC6 ^ l[7:0];
         m = 8'hFF >> (3 - (l > 3 ? 3 : l));
         len_sel <= (l > 3) ? 2'd3 : l[1:0];
         nb <= (l > 3) ? 4'd8 : 4'(5 + l);
         @(posedge ref_clk);
         fork
            model_u.send(d, l < 4);
            begin
               k = 0;
               while (rx_valid_q !== 1'b1 && k < 4000) begin
                  @(posedge ref_clk);
                  k++;
               end
               chk("rx data", d & m, rx_data_q);
               chk("rx frame error", l > 3, rx_frame_err_q);
            end
         join
         repeat ((l + 1) * 100) @(posedge ref_clk);
      end
      $display("receive done");
   endtask
   // 25 MHz reference
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      len_sel = 2'd3;
      stop_sel = 2'd0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      dtr_req = 1'b0;
      rts_req = 1'b0;
      cts_on = 1'b1;
      dsr_on = 1'b1;
      cd_on = 1'b1;
      nb = 4'd8;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      t_modem;
      t_tx_len;
      t_stop;
      t_fifo;
      t_rx;
      end_of_test;
   end
   // hang guard well above the expected run
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         error_cnt++;
         end_of_test;
      end
   end
endmodule // tb_async_serial_dte_port
`default_nettype wire
